// [rtl/oto_consts.svh]
// constants of the output test and override logic
//
// Notes on behaviour
// - disarm needs unlatched, no hold, control, command
// - latched or holding contacts refuse disarm
// - disarm permanent or timed, timed ends normally
// - zone interlock and supervision never disarmed
// - force permanent or timed, timed ends normally
// - group force beats single force
// - disarmed contact ignores force commands
// - force acts only when armed and commanded
// - supervision drop lasts five seconds, then restores
// - forced supervision drop logs no message
// - trip force asserts trip command output
// - maintenance state kept nonvolatile, restored
// - manual maintenance only from local panel
// - source change refused while activation asserted
// - complementary maintenance active/inactive outputs
// - green only after boot with protection running
// - service menu request triggers reboot
// - flag calculated versus configured phase sequence
`ifndef OTO_CONSTS_SVH
`define OTO_CONSTS_SVH

// ----------------------------------------
// structure
// ----------------------------------------
`define OTO_NGRP 2
`define OTO_NOUT 8
`define OTO_TW 8

// ----------------------------------------
// timing
// ----------------------------------------
`define OTO_CLK_HZ 125000000
`define OTO_SEC_CYCLES (`OTO_CLK_HZ * 1)
`define OTO_SC_DROP_S 8'h05

// ----------------------------------------
// reset values
// ----------------------------------------
`define OTO_OUT_RST 1'b0
`define OTO_MAINT_RST 1'b0

`endif

// [rtl/oto_pkg.sv]
// types shared by the output test and override logic
`include "oto_consts.svh"

package oto_pkg;

  // per assembly group service commands; *_cmd fields are one-cycle pulses
  typedef struct packed {
    logic disarm_ctrl;
    logic disarm_cmd;
    logic disarm_timed;
    logic rearm_cmd;
    logic force_all_cmd;
    logic force_all_val;
    logic [`OTO_NOUT-1:0] single_force_cmd;
    logic [`OTO_NOUT-1:0] single_force_val;
    logic force_timed;
    logic force_release;
  } oto_grp_cmd_t;

  // maintenance mode activation sources
  typedef enum logic [2:0] {
    OTO_SRC_MANUAL = 3'b001,
    OTO_SRC_COMM = 3'b010,
    OTO_SRC_DI = 3'b100
  } oto_src_t;

  // maintenance mode operator inputs
  typedef struct packed {
    logic manual_on;
    logic manual_off;
    logic from_panel;
    logic comm_active;
    logic src_change;
    logic [2:0] src_new;
  } oto_maint_cmd_t;

  // general status inputs
  typedef struct packed {
    logic boot_done;
    logic prot_running;
    logic reboot_req;
    logic [1:0] phase_seq_calc;
    logic [1:0] phase_seq_set;
  } oto_sys_in_t;

endpackage : oto_pkg

// [rtl/oto_timer.sv]
// whole-second countdown timer used for timed disarm, timed force and supervision drop
`timescale 1ns/1ns
`include "oto_consts.svh"

module oto_timer #(
  parameter int unsigned SEC_CYCLES = `OTO_SEC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [`OTO_TW-1:0] load,
  output logic running,
  output logic expire
);
  import oto_pkg::*;

  logic [`OTO_TW-1:0] count;
  logic [31:0] sub;
  logic sec_wrap;

  assign sec_wrap = (sub == SEC_CYCLES - 1);

  // prescaler restarts with every start so the run is exact to the cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sub <= 32'h0000_0000;
    end else if (start || !running || sec_wrap) begin
      sub <= 32'h0000_0000;
    end else begin
      sub <= sub + 32'h0000_0001;
    end
  end

  // seconds remaining; stop wins over a running count
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (stop) begin
      count <= '0;
    end else if (start) begin
      count <= load;
    end else if (running && sec_wrap) begin
      count <= count - `OTO_TW'(1);
    end
  end

  assign running = (count != '0);

  // a zero load ends at once so a timed mode never sticks
  always_comb begin
    expire = 1'b0;
    if (!stop && start && load == '0) begin
      expire = 1'b1;
    end else if (!stop && !start && running && sec_wrap && count == `OTO_TW'(1)) begin
      expire = 1'b1;
    end
  end

endmodule : oto_timer

// [rtl/oto_override.sv]
// service override logic: disarm, force, trip force, supervision drop, maintenance mode
`timescale 1ns/1ns
`include "oto_consts.svh"

module oto_override #(
  parameter int unsigned SEC_CYCLES = `OTO_SEC_CYCLES
) (
  input wire logic core_clk,
  input wire logic rst,
  // normal protection logic, same clock
  input wire logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] prot_out,
  input wire logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] latched,
  input wire logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] hold_running,
  input wire logic zone_interlock_in,
  input wire logic prot_trip,
  input wire logic selfsup_fault,
  // operator commands
  input wire oto_pkg::oto_grp_cmd_t [`OTO_NGRP-1:0] grp_cmd,
  input wire logic [`OTO_TW-1:0] disarm_time_s,
  input wire logic [`OTO_TW-1:0] force_time_s,
  input wire logic trip_force,
  input wire logic supervision_drop_request,
  input wire oto_pkg::oto_maint_cmd_t maint_cmd,
  input wire logic maint_di_pin,
  input wire oto_pkg::oto_sys_in_t sys_in,
  // nonvolatile store of the maintenance state
  input wire logic nv_valid,
  input wire logic nv_maint,
  output logic nv_write,
  output logic nv_data,
  // contacts and status
  output logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_out,
  output logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_disarmed,
  output logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_forced,
  output logic zone_interlock_out,
  output logic self_supervision_contact,
  output logic selfsup_log_event,
  output logic trip_cmd,
  output logic maint_active,
  output logic maint_inactive,
  output logic [2:0] maint_src,
  output logic src_change_refused,
  output logic led_green,
  output logic led_fault,
  output logic reboot,
  output logic phase_seq_mismatch,
  output logic phase_seq_match
);
  import oto_pkg::*;

  // what each contact does:
  //   disarmed  -> contact held open, force commands ignored
  //   forced    -> contact shows the stored force value
  //   otherwise -> contact follows the protection logic
  // every contact output leaves through one register stage,
  // so a timed end shows the protection value one edge later.
  // the zone interlock and supervision paths never read the
  // disarm state, which keeps them outside any disarm or force action.

  // ----------------------------------------
  // per group disarm and force
  // ----------------------------------------
  logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] disarmed;
  logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] forced;
  logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] force_val;
  logic [`OTO_NGRP-1:0] grp_forced;
  logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] next_out;

  // one slice per assembly group; each slice owns its disarm
  // timer and its force timer, so groups never share a countdown
  genvar g;
  generate
    for (g = 0; g < `OTO_NGRP; g = g + 1) begin : grp
      logic dis_go;
      logic dis_end;
      logic dis_expire;
      logic [`OTO_NOUT-1:0] eligible;
      logic frc_go;
      logic frc_expire;
      logic [`OTO_NOUT-1:0] single_go;

      // a contact may only go disarmed while unlatched and not holding
      assign dis_go = grp_cmd[g].disarm_cmd & grp_cmd[g].disarm_ctrl;
      assign eligible = ~latched[g] & ~hold_running[g];
      // control dropped or rearm ends a disarm of either kind
      assign dis_end = ~grp_cmd[g].disarm_ctrl | grp_cmd[g].rearm_cmd;

      // timed disarm; a permanent disarm cancels a running timer
      // a new timed disarm restarts the count from the full load
      oto_timer #(
        .SEC_CYCLES(SEC_CYCLES)
      ) u_dis_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .start(dis_go & grp_cmd[g].disarm_timed),
        .stop(dis_end | (dis_go & ~grp_cmd[g].disarm_timed)),
        .load(disarm_time_s),
        .running(),
        .expire(dis_expire)
      );

      // disarm state; refused contacts simply stay armed
      // the end of a disarm is checked first: a zero timed load
      // expires in the very cycle it starts and must not stick
      // eligibility is sampled only at the command edge; a contact
      // that latches later stays disarmed until the disarm ends
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          disarmed[g] <= '0;
        end else if (dis_end || dis_expire) begin
          disarmed[g] <= '0;
        end else if (dis_go) begin
          disarmed[g] <= disarmed[g] | eligible;
        end
      end

      // force requests take only armed contacts
      // single_go stays empty while a group force holds the group
      assign frc_go = grp_cmd[g].force_all_cmd | (|single_go);
      assign single_go = grp_forced[g] ? '0 : (grp_cmd[g].single_force_cmd & ~disarmed[g]);

      oto_timer #(
        .SEC_CYCLES(SEC_CYCLES)
      ) u_frc_tmr (
        .core_clk(core_clk),
        .rst(rst),
        .start(frc_go & grp_cmd[g].force_timed),
        .stop(grp_cmd[g].force_release | (frc_go & ~grp_cmd[g].force_timed)),
        .load(force_time_s),
        .running(),
        .expire(frc_expire)
      );

      // force state; the group force overrides any single force in the group
      // release and expiry win over a new command in the same cycle,
      // so a zero timed load never leaves a contact forced
      // a single force inside a held group force is dropped, not queued
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          forced[g] <= '0;
          force_val[g] <= '0;
          grp_forced[g] <= 1'b0;
        end else if (grp_cmd[g].force_release || frc_expire) begin
          forced[g] <= '0;
          grp_forced[g] <= 1'b0;
        end else if (grp_cmd[g].force_all_cmd) begin
          forced[g] <= ~disarmed[g];
          force_val[g] <= {`OTO_NOUT{grp_cmd[g].force_all_val}};
          grp_forced[g] <= 1'b1;
        end else if (|single_go) begin
          forced[g] <= forced[g] | single_go;
          force_val[g] <= (force_val[g] & ~single_go) | (grp_cmd[g].single_force_val & single_go);
        end
      end

      // disarmed dominates, then force, then normal protection value
      always_comb begin
        next_out[g] = (forced[g] & ~disarmed[g] & force_val[g])
                    | (~forced[g] & ~disarmed[g] & prot_out[g]);
      end
    end
  endgenerate

  // contact drivers, one register stage
  // the forced status masks disarmed bits so it never shows a
  // force that the contact cannot carry out
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      contact_out <= '0;
      contact_disarmed <= '0;
      contact_forced <= '0;
    end else begin
      contact_out <= next_out;
      contact_disarmed <= disarmed;
      contact_forced <= forced & ~disarmed;
    end
  end

  // ----------------------------------------
  // zone interlock, trip force, supervision contact
  // ----------------------------------------
  logic sc_dropping;
  logic sc_expire;

  // fixed drop interval, restarted by a repeated request
  // the request itself also clears the contact, so the contact
  // opens on the edge that takes the request, the same edge on which
  // the timer starts to report running
  // limitation: a repeated request restarts the full interval
  oto_timer #(
    .SEC_CYCLES(SEC_CYCLES)
  ) u_sc_tmr (
    .core_clk(core_clk),
    .rst(rst),
    .start(supervision_drop_request),
    .stop(1'b0),
    .load(`OTO_SC_DROP_S),
    .running(sc_dropping),
    .expire(sc_expire)
  );

  // interlock and supervision bypass every disarm path by construction
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      zone_interlock_out <= `OTO_OUT_RST;
      self_supervision_contact <= `OTO_OUT_RST;
      selfsup_log_event <= 1'b0;
      trip_cmd <= `OTO_OUT_RST;
    end else begin
      zone_interlock_out <= zone_interlock_in;
      // energized means healthy; the forced drop de-energizes it
      self_supervision_contact <= sys_in.boot_done & ~selfsup_fault
                                & ~sc_dropping & ~supervision_drop_request;
      // the forced drop is not a fault, so it never reaches the log
      selfsup_log_event <= selfsup_fault;
      trip_cmd <= prot_trip | trip_force;
    end
  end

  // ----------------------------------------
  // maintenance mode
  // ----------------------------------------
  logic di_meta;
  logic di_sync;
  logic manual_state;
  logic src_signal;
  logic next_maint;
  logic nv_loaded;
  oto_src_t src;

  // the maintenance state waits for the stored copy until the store
  // reports valid; before that the outputs keep their reset values,
  // so downstream setting-group logic never sees a false change
  // hazard: the digital input is asynchronous, so only the second
  // synchroniser stage feeds the source multiplexer
  // the digital input comes from a pin; two stages before use
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      di_meta <= 1'b0;
      di_sync <= 1'b0;
    end else begin
      di_meta <= maint_di_pin;
      di_sync <= di_meta;
    end
  end

  // manual switch only honoured from the local panel
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      manual_state <= `OTO_MAINT_RST;
    end else if (!nv_loaded && nv_valid) begin
      manual_state <= nv_maint;
    end else if (maint_cmd.from_panel && maint_cmd.manual_on) begin
      manual_state <= 1'b1;
    end else if (maint_cmd.from_panel && maint_cmd.manual_off) begin
      manual_state <= 1'b0;
    end
  end

  // activation signal of the currently selected source
  always_comb begin
    case (src)
      OTO_SRC_MANUAL: src_signal = manual_state;
      OTO_SRC_COMM: src_signal = maint_cmd.comm_active;
      OTO_SRC_DI: src_signal = di_sync;
      default: src_signal = 1'b0;
    endcase
  end

  // source selection; a change is refused while the activation is asserted
  // a code that is not one-hot is refused like a blocked change,
  // so the selector can never leave the three legal sources
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      src <= OTO_SRC_MANUAL;
      src_change_refused <= 1'b0;
    end else begin
      src_change_refused <= 1'b0;
      if (maint_cmd.src_change) begin
        if (src_signal) begin
          src_change_refused <= 1'b1;
        end else if (maint_cmd.src_new == OTO_SRC_MANUAL || maint_cmd.src_new == OTO_SRC_COMM
                     || maint_cmd.src_new == OTO_SRC_DI) begin
          src <= oto_src_t'(maint_cmd.src_new);
        end else begin
          src_change_refused <= 1'b1; // not a one-hot code
        end
      end
    end
  end

  assign maint_src = src;

  // until the stored state is back the restored value rules
  assign next_maint = (!nv_loaded && nv_valid) ? nv_maint : src_signal;

  // maintenance state and the write-back to the nonvolatile store
  // nv_write is a one-cycle pulse; the store must take it on that edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      nv_loaded <= 1'b0;
      maint_active <= `OTO_MAINT_RST;
      maint_inactive <= ~`OTO_MAINT_RST;
      nv_write <= 1'b0;
      nv_data <= `OTO_MAINT_RST;
    end else begin
      if (nv_valid) begin
        nv_loaded <= 1'b1;
      end
      if (nv_loaded || nv_valid) begin
        maint_active <= next_maint;
        maint_inactive <= ~next_maint;
      end
      // write only on a change once the store has been read back
      nv_write <= nv_loaded && (next_maint != maint_active);
      nv_data <= next_maint;
    end
  end

  // ----------------------------------------
  // general status: led, reboot, phase sequence
  // ----------------------------------------
  // all status outputs are registered so that they change together
  // on one edge; after reset the two phase flags are complements,
  // each wanted by a different consumer; reset holds both low
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      led_green <= 1'b0;
      led_fault <= 1'b1;
      reboot <= 1'b0;
      phase_seq_mismatch <= 1'b0;
      phase_seq_match <= 1'b0;
    end else begin
      led_green <= sys_in.boot_done & sys_in.prot_running;
      led_fault <= ~(sys_in.boot_done & sys_in.prot_running);
      reboot <= sys_in.reboot_req;
      phase_seq_mismatch <= (sys_in.phase_seq_calc != sys_in.phase_seq_set);
      phase_seq_match <= (sys_in.phase_seq_calc == sys_in.phase_seq_set);
    end
  end

endmodule : oto_override

// [bench/oto_breaker_model.sv]
// breaker model at the far side of the trip command
`timescale 1ns/1ns

module oto_breaker_model #(
  parameter int OPEN_DLY = 1
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic trip_cmd,
  output logic breaker_open
);
  int cnt;

  // opens after OPEN_DLY cycles of trip command; stays open, no reclose
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      cnt <= 0;
      breaker_open <= 1'b0;
    end else if (trip_cmd && !breaker_open) begin
      cnt <= cnt + 1;
      if (cnt + 1 >= OPEN_DLY) begin
        breaker_open <= 1'b1;
      end
    end
  end
endmodule : oto_breaker_model

// [bench/oto_override_chk.sv]
// assertion checker of the service override logic
`timescale 1ns/1ns
`include "oto_consts.svh"

module oto_override_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic trip_force,
  input wire logic trip_cmd,
  input wire logic zone_interlock_in,
  input wire logic zone_interlock_out,
  input wire logic supervision_drop_request,
  input wire logic self_supervision_contact,
  input wire logic selfsup_fault,
  input wire logic selfsup_log_event,
  input wire oto_pkg::oto_sys_in_t sys_in,
  input wire oto_pkg::oto_maint_cmd_t maint_cmd,
  input wire logic led_green,
  input wire logic reboot,
  input wire logic phase_seq_mismatch,
  input wire logic phase_seq_match,
  input wire logic maint_active,
  input wire logic maint_inactive,
  input wire logic src_change_refused,
  input wire logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_out,
  input wire logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_disarmed,
  input wire logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_forced
);
  import oto_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  property p_trip; trip_force |=> trip_cmd; endproperty
  a_trip: assert property (p_trip) else $error("trip force lost");
  property p_zone; zone_interlock_in |=> zone_interlock_out; endproperty
  a_zone: assert property (p_zone) else $error("zone output blocked");
  property p_drop; supervision_drop_request |=> !self_supervision_contact; endproperty
  a_drop: assert property (p_drop) else $error("supervision not dropped");
  property p_nolog; !selfsup_fault [*2] |-> !selfsup_log_event; endproperty
  a_nolog: assert property (p_nolog) else $error("log event without fault");
  property p_maint; maint_active != maint_inactive; endproperty
  a_maint: assert property (p_maint) else $error("maintenance flags equal");
  property p_green; led_green |-> $past(sys_in.boot_done) && $past(sys_in.prot_running); endproperty
  a_green: assert property (p_green) else $error("green too early");
  property p_reboot; sys_in.reboot_req |=> reboot; endproperty
  a_reboot: assert property (p_reboot) else $error("reboot missing");
  property p_phase;
    sys_in.phase_seq_calc != sys_in.phase_seq_set |=> phase_seq_mismatch && !phase_seq_match;
  endproperty
  a_phase: assert property (p_phase) else $error("phase flags wrong");
  property p_dom; (contact_disarmed & (contact_out | contact_forced)) == '0; endproperty
  a_dom: assert property (p_dom) else $error("disarmed contact driven");
  property p_src;
    maint_cmd.src_change && !(maint_cmd.src_new inside {3'h1, 3'h2, 3'h4}) |=> src_change_refused;
  endproperty
  a_src: assert property (p_src) else $error("bad source accepted");
endmodule : oto_override_chk

bind oto_override oto_override_chk chk_i (.*);

// [bench/test_output_test_override_logic.sv]
// self-checking bench of the service override logic
`timescale 1ns/1ns
`include "oto_consts.svh"

module test_output_test_override_logic;
  import oto_pkg::*;
  localparam int SEC = 10;
  logic core_clk, rst, zone_interlock_in, prot_trip, selfsup_fault, trip_force, supervision_drop_request;
  logic maint_di_pin, nv_valid, nv_maint, nv_write, nv_data, zone_interlock_out, self_supervision_contact;
  logic selfsup_log_event, trip_cmd, maint_active, maint_inactive, src_change_refused, led_green, led_fault;
  logic reboot, phase_seq_mismatch, phase_seq_match, breaker_open;
  logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] prot_out, latched, hold_running, contact_out, contact_disarmed;
  logic [`OTO_NGRP-1:0][`OTO_NOUT-1:0] contact_forced;
  logic [`OTO_TW-1:0] disarm_time_s, force_time_s;
  logic [2:0] maint_src;
  oto_grp_cmd_t [`OTO_NGRP-1:0] grp_cmd;
  oto_maint_cmd_t maint_cmd;
  oto_sys_in_t sys_in;
  int n_fail, tests_run, cyc;

  oto_override #(.SEC_CYCLES(SEC)) oto_override_i (.*);
  oto_breaker_model oto_breaker_model_i (.core_clk, .rst, .trip_cmd, .breaker_open);

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // --------------------------------
  // helpers
  // --------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic e();
    @(posedge core_clk);
  endtask : e

  // settle a little after the edge so registered outputs have landed
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : w

  // group command: pulses cleared after one edge, levels kept
  task automatic gp(input int g, input logic [23:0] v);
    e();
    grp_cmd[g] <= v;
    e();
    grp_cmd[g] <= v & 24'hA403FE;
    #1;
  endtask : gp

  // maintenance command: only comm_active survives the pulse
  task automatic mp(input logic [7:0] v);
    e();
    maint_cmd <= v;
    e();
    maint_cmd <= v & 8'h10;
    #1;
  endtask : mp

  task automatic finish_test();
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  // hang guard, well above the length of the sequence
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1500) begin
      n_fail++;
      finish_test();
    end
  end

  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    rst = 1'b1; prot_out = '0; latched = '0; hold_running = '0; zone_interlock_in = 1'b0;
    prot_trip = 1'b0; selfsup_fault = 1'b0; grp_cmd = '0; disarm_time_s = 8'h01; force_time_s = 8'h02;
    trip_force = 1'b0; supervision_drop_request = 1'b0; maint_cmd = '0; maint_di_pin = 1'b0;
    sys_in = '0; nv_valid = 1'b0; nv_maint = 1'b0; n_fail = 0; tests_run = 0; cyc = 0;
    w(6);
    chk({maint_inactive, led_fault, maint_src}, 16'h19);
    e(); rst <= 1'b0; nv_maint <= 1'b1; nv_valid <= 1'b1;
    sys_in <= 7'h41; // booted, protection not yet running
    e(); nv_valid <= 1'b0;
    w(2);
    chk({maint_active, maint_inactive, led_green}, 16'h4);
    // maintenance sources
    mp(8'h40); w(2); chk(maint_active, 1);
    mp(8'h0C); chk(src_change_refused, 1);
    mp(8'h60); w(1); chk({nv_write, maint_active}, 16'h2);
    w(1); chk({maint_active, maint_inactive, nv_data, nv_write}, 16'h4);
    mp(8'h0B); chk(src_change_refused, 1);
    mp(8'h0C); w(1); chk(maint_src, 16'h4);
    e(); maint_di_pin <= 1'b1;
    w(4); chk(maint_active, 1);
    mp(8'h0A); w(1); chk(maint_src, 16'h4);
    e(); maint_di_pin <= 1'b0;
    w(4); mp(8'h0A); mp(8'h10); w(2); chk({maint_src, maint_active}, 16'h5);
    // disarm with a latched and a holding contact
    e(); prot_out <= 16'hFFFF; latched[0] <= 8'h01; hold_running[0] <= 8'h02; zone_interlock_in <= 1'b1;
    gp(0, 24'hC00000); w(2);
    chk(contact_disarmed[0], 16'hFC);
    chk({contact_out[0], zone_interlock_out, self_supervision_contact}, 16'h00F);
    e(); prot_out[0] <= 8'h00;
    gp(0, 24'h83FFFC); w(2);
    chk({contact_out[0], contact_forced[0]}, 16'h0303);
    gp(0, 24'h000001); w(2);
    chk({contact_out[0], contact_disarmed[0]}, 16'h0);
    // group force against single force in the same cycle
    gp(1, 24'h0BFFFC); w(2); chk(contact_out[1], 16'h0);
    gp(1, 24'h080404); w(2); chk(contact_out[1], 16'h0);
    gp(1, 24'h000001); w(2); chk(contact_out[1], 16'hFF);
    // timed force, two seconds
    e(); latched[0] <= 8'h00; hold_running[0] <= 8'h00;
    gp(0, 24'h000406); w(2); chk(contact_out[0], 16'h1);
    w(14); chk(contact_out[0], 16'h1);
    w(5); chk(contact_out[0], 16'h0);
    // timed disarm, one second
    e(); prot_out[0] <= 8'hFF;
    gp(0, 24'hE00000); w(2); chk({contact_out[0], contact_disarmed[0]}, 16'h00FF);
    w(9); chk(contact_out[0], 16'hFF);
    // supervision contact drop
    e(); supervision_drop_request <= 1'b1;
    e(); supervision_drop_request <= 1'b0;
    w(1); chk({self_supervision_contact, selfsup_log_event}, 16'h0);
    w(49); chk(self_supervision_contact, 0);
    w(1); chk(self_supervision_contact, 1);
    // trip force reaches the breaker
    e(); trip_force <= 1'b1;
    w(2); chk({trip_cmd, breaker_open}, 16'h3);
    // status lamps, phase sequence, reboot
    e(); trip_force <= 1'b0; sys_in <= 7'h61;
    w(2); chk({led_green, led_fault, phase_seq_mismatch, phase_seq_match}, 16'hA);
    e(); sys_in.phase_seq_set <= 2'h0;
    w(2); chk({phase_seq_mismatch, phase_seq_match}, 16'h1);
    e(); sys_in.reboot_req <= 1'b1;
    e(); sys_in.reboot_req <= 1'b0;
    #1; chk(reboot, 1);
    finish_test();
  end
endmodule : test_output_test_override_logic
